// ===== rtl/ubds_defs.vh
// ubds_defs.vh: offsets, field positions, reset values and timing counts
// assumes: included by every design file of the block by bare name
`ifndef UBDS_DEFS_VH
`define UBDS_DEFS_VH
// =====================================================
// register map (APB byte addresses, one word each)
`define UBDS_DIV_LOW 8'h00
`define UBDS_DIV_HIGH 8'h04
`define UBDS_INT_ENABLE 8'h08
`define UBDS_FIFO_CTRL 8'h0C
`define UBDS_LINE_CTRL 8'h10
`define UBDS_MODEM_CTRL 8'h14
`define UBDS_ENH_FEAT 8'h18
`define UBDS_STATUS 8'h1C
`define UBDS_PRESCALE 8'h20
// =====================================================
// field positions
`define UBDS_FCR_FIFO_EN 0
`define UBDS_FCR_MODE 3
`define UBDS_IER_SLEEP 4
`define UBDS_EFR_ENH 4
`define UBDS_MCR_PRESC 7
// bits guarded by enhanced-functions enable
`define UBDS_MCR_ENH_MASK 8'hE0
`define UBDS_FCR_ENH_MASK 8'h30
`define UBDS_IER_ENH_MASK 8'hF0
// =====================================================
// reset values and timing
`define UBDS_LCR_RESET 8'h1D
`define UBDS_OVERSAMPLE 16
`define UBDS_PRESC_DIV 4
`define UBDS_TIMEOUT_BASE 12
`define UBDS_TIMEOUT_MULT 4
`endif

// ===== rtl/ubds_baud_gen.v
// ubds_baud_gen.v: prescaler plus 16-bit reloading divisor, 16x tick out
// assumes: crystal input appears as a one-cycle enable on the core clock
`timescale 1ns/100ps
`include "ubds_defs.vh"
module ubds_baud_gen #(
  parameter DIV_W = 16
) (
  input wire clk_in,
  input wire rst_in,
  input wire crystal_input_en_in,
  input wire run_in,
  input wire presc4_in,
  input wire [DIV_W-1:0] divisor_in,
  output reg tick16_out
);
  reg [1:0] presc_cnt;
  reg [DIV_W-1:0] div_cnt;
  wire presc_en;
  // =====================================================
  // prescaler: every crystal pulse, or one in four
  assign presc_en = crystal_input_en_in && run_in && (!presc4_in || presc_cnt == 2'd3); // RULE2
  always @(posedge clk_in) begin
    if (rst_in) begin
      presc_cnt <= 2'd0;
    end else if (crystal_input_en_in && run_in) begin
      presc_cnt <= presc4_in ? presc_cnt + 2'd1 : 2'd0;
    end
  end
  // =====================================================
  // divisor counter, reloads on expiry, silent when divisor zero
  always @(posedge clk_in) begin
    if (rst_in) begin
      div_cnt <= {DIV_W{1'b0}};
      tick16_out <= 1'b0;
    end else begin
      tick16_out <= 1'b0;
      if (divisor_in == {DIV_W{1'b0}}) begin
        div_cnt <= {DIV_W{1'b0}}; // RULE4
      end else if (presc_en) begin
        if (div_cnt <= {{(DIV_W-1){1'b0}}, 1'b1}) begin
          div_cnt <= divisor_in; // RULE23
          tick16_out <= 1'b1; // RULE1
        end else begin
          div_cnt <= div_cnt - {{(DIV_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// ===== rtl/ubds_rx_idle.v
// ubds_rx_idle.v: receive-line idle and timeout counter in bit times
// assumes: rx line already synchronised, tick is the 16x baud tick
`timescale 1ns/100ps
`include "ubds_defs.vh"
module ubds_rx_idle #(
  parameter CNT_W = 10
) (
  input wire clk_in,
  input wire rst_in,
  input wire rx_in,
  input wire tick16_in,
  input wire [1:0] word_len_in,
  input wire rx_has_data_in,
  output reg idle_out,
  output reg timeout_out
);
  reg [CNT_W-1:0] sub_cnt;
  reg [CNT_W-1:0] bit_cnt;
  wire [CNT_W-1:0] limit;
  wire [31:0] limit_full;
  // =====================================================
  // bits = 4 x word length (5..8) + 12, worked out wide then cut to the counter
  assign limit_full = `UBDS_TIMEOUT_MULT * ({30'h0000_0000, word_len_in} + 5) + `UBDS_TIMEOUT_BASE; // RULE21
  assign limit = limit_full[CNT_W-1:0];
  always @(posedge clk_in) begin
    if (rst_in) begin
      sub_cnt <= {CNT_W{1'b0}};
      bit_cnt <= {CNT_W{1'b0}};
      idle_out <= 1'b0;
      timeout_out <= 1'b0;
    end else if (!rx_in) begin
      sub_cnt <= {CNT_W{1'b0}};
      bit_cnt <= {CNT_W{1'b0}};
      idle_out <= 1'b0;
      timeout_out <= 1'b0;
    end else if (tick16_in && !idle_out) begin
      sub_cnt <= (sub_cnt == `UBDS_OVERSAMPLE - 1) ? {CNT_W{1'b0}} : sub_cnt + 1'b1;
      if (sub_cnt == `UBDS_OVERSAMPLE - 1) begin
        bit_cnt <= bit_cnt + 1'b1;
        if (bit_cnt + 1'b1 >= limit) begin
          idle_out <= 1'b1; // RULE21
        end
      end
    end else begin
      timeout_out <= idle_out && rx_has_data_in; // RULE21
    end
  end
endmodule

// ===== rtl/ubds_top.v
// ubds_top.v: baud generation, transfer-ready signalling and sleep control
// assumes: APB master on the core clock; fifo status from the datapath
// Notes on behaviour
// RULE1: 16x tick is prescaled clock divided by divisor.
// RULE2: prescale by four from strap at reset or control bit, else one.
// RULE3: divisor is low byte plus high byte, both written by host.
// RULE4: zero divisor stops the baud tick entirely.
// RULE5: one divisor clocks both transmitter and receiver.
// RULE6: 1.8432 MHz: divisor 12 gives 9600, 2304 gives 50 baud.
// RULE7: 3.072 MHz: divisor 20 gives 9600, 3840 gives 50 baud.
// RULE8: mode bit picks single-character or block transfer signalling.
// RULE9: single mode: transmit ready while holding space empty.
// RULE10: single mode: receive ready while any character held.
// RULE11: block mode: transmit ready at trigger spaces, off when full.
// RULE12: block mode: receive ready at trigger or timeout, off empty/error.
// RULE13: sleep allowed only with enhanced enable and sleep enable.
// RULE14: sleep needs idle line, empty transmit, no other interrupts.
// RULE15: no sleep while receive fifo holds characters.
// RULE16: asleep, internal and baud clocks stop.
// RULE17: wake on receive or modem pin change, or transmit write.
// RULE18: host must not write divisor while asleep.
// RULE19: register selected by address, qualified by other bits.
// RULE20: guarded control bits change only with enhanced functions on.
// RULE21: idle and timeout after 4 x word length + 12 high bits.
// RULE22: reset drives receive ready high, transmit ready low.
// RULE23: counter reloads divisor on expiry; new divisor at next reload.
`timescale 1ns/100ps
`include "ubds_defs.vh"
module ubds_top #(
  parameter DIV_W = 16,
  parameter MODEM_W = 4
) (
  input wire CORE_CLK_IN,
  input wire RST_IN,
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire PWRITE_IN,
  input wire [7:0] PADDR_IN,
  input wire [31:0] PWDATA_IN,
  output reg [31:0] PRDATA_OUT,
  output wire PREADY_OUT,
  output wire PSLVERR_OUT,
  input wire CRYSTAL_INPUT_IN,
  input wire PRESCALE_SELECT_PIN_IN,
  input wire RX_LINE_IN,
  input wire [MODEM_W-1:0] MODEM_PINS_IN,
  input wire TX_FIFO_EMPTY_IN,
  input wire TX_FIFO_FULL_IN,
  input wire TX_SHIFT_EMPTY_IN,
  input wire TX_TRIGGER_IN,
  input wire TX_WRITE_IN,
  input wire RX_FIFO_EMPTY_IN,
  input wire RX_TRIGGER_IN,
  input wire ERROR_IN_FIFO_FLAG_IN,
  input wire OTHER_INT_PENDING_IN,
  output wire BAUD_TICK16_OUT,
  output wire RX_TIMEOUT_OUT,
  output reg SLEEP_OUT,
  output wire UART_CLK_EN_OUT,
  output reg TRANSMIT_READY_N_OUT,
  output reg RECEIVE_READY_N_OUT
);
  reg [7:0] divisor_low_byte;
  reg [7:0] divisor_high_byte;
  reg [7:0] interrupt_enable_register;
  reg [7:0] fifo_control_register;
  reg [7:0] line_control;
  reg [7:0] modem_control_register;
  reg [7:0] enhanced_features;
  reg strap_presc4;
  reg [1:0] strap_sync;
  reg rst_d;
  reg [2:0] crystal_input_sync;
  reg [1:0] rx_sync;
  reg rx_prev;
  reg [MODEM_W-1:0] modem_s1;
  reg [MODEM_W-1:0] modem_s2;
  reg [MODEM_W-1:0] modem_prev;
  reg wake_seen;
  reg next_transmit_ready_n_n;
  reg next_receive_ready_n_n;
  wire wr;
  wire rd;
  wire enh;
  wire crystal_input_en;
  wire presc4;
  wire rx_idle;
  wire rx_timeout;
  wire wake;
  wire sleep_ok;
  wire block_mode;
  wire [DIV_W-1:0] divisor;
  // =====================================================
  // apb slave: always ready, error on unmapped address
  assign wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign rd = PSEL_IN && !PWRITE_IN;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && (PADDR_IN > `UBDS_PRESCALE || PADDR_IN[1:0] != 2'b00);
  assign enh = enhanced_features[`UBDS_EFR_ENH];
  assign divisor = {divisor_high_byte, divisor_low_byte}; // RULE3
  // register writes, guarded bits kept unless enhanced on
  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      interrupt_enable_register <= 8'h00;
      fifo_control_register <= 8'h00;
      line_control <= `UBDS_LCR_RESET;
      modem_control_register <= 8'h00;
      enhanced_features <= 8'h00;
    end else if (wr && !PSLVERR_OUT) begin
      if (PADDR_IN == `UBDS_INT_ENABLE) begin // RULE19
        interrupt_enable_register <= enh ? PWDATA_IN[7:0] :
          ((interrupt_enable_register & `UBDS_IER_ENH_MASK) | (PWDATA_IN[7:0] & ~`UBDS_IER_ENH_MASK)); // RULE20
      end else if (PADDR_IN == `UBDS_FIFO_CTRL) begin
        fifo_control_register <= enh ? PWDATA_IN[7:0] :
          ((fifo_control_register & `UBDS_FCR_ENH_MASK) | (PWDATA_IN[7:0] & ~`UBDS_FCR_ENH_MASK)); // RULE20
      end else if (PADDR_IN == `UBDS_LINE_CTRL) begin
        line_control <= PWDATA_IN[7:0];
      end else if (PADDR_IN == `UBDS_MODEM_CTRL) begin
        modem_control_register <= enh ? PWDATA_IN[7:0] :
          ((modem_control_register & `UBDS_MCR_ENH_MASK) | (PWDATA_IN[7:0] & ~`UBDS_MCR_ENH_MASK)); // RULE20
      end else if (PADDR_IN == `UBDS_ENH_FEAT) begin
        enhanced_features <= PWDATA_IN[7:0];
      end
    end
  end
  // divisor bytes survive reset; host keeps off them while asleep
  always @(posedge CORE_CLK_IN) begin
    if (wr && !PSLVERR_OUT && PADDR_IN == `UBDS_DIV_LOW) begin // RULE18
      divisor_low_byte <= PWDATA_IN[7:0];
    end
    if (wr && !PSLVERR_OUT && PADDR_IN == `UBDS_DIV_HIGH) begin
      divisor_high_byte <= PWDATA_IN[7:0];
    end
  end
  // read mux
  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      PRDATA_OUT <= 32'h0000_0000;
    end else if (rd && !PENABLE_IN) begin
      if (PADDR_IN == `UBDS_DIV_LOW) begin
        PRDATA_OUT <= {24'h00_0000, divisor_low_byte};
      end else if (PADDR_IN == `UBDS_DIV_HIGH) begin
        PRDATA_OUT <= {24'h00_0000, divisor_high_byte};
      end else if (PADDR_IN == `UBDS_INT_ENABLE) begin
        PRDATA_OUT <= {24'h00_0000, interrupt_enable_register};
      end else if (PADDR_IN == `UBDS_FIFO_CTRL) begin
        PRDATA_OUT <= {24'h00_0000, fifo_control_register};
      end else if (PADDR_IN == `UBDS_LINE_CTRL) begin
        PRDATA_OUT <= {24'h00_0000, line_control};
      end else if (PADDR_IN == `UBDS_MODEM_CTRL) begin
        PRDATA_OUT <= {24'h00_0000, modem_control_register};
      end else if (PADDR_IN == `UBDS_ENH_FEAT) begin
        PRDATA_OUT <= {24'h00_0000, enhanced_features};
      end else if (PADDR_IN == `UBDS_STATUS) begin
        PRDATA_OUT <= {26'h000_0000, rx_timeout, rx_idle, SLEEP_OUT, !RECEIVE_READY_N_OUT,
          !TRANSMIT_READY_N_OUT, divisor == {DIV_W{1'b0}}};
      end else if (PADDR_IN == `UBDS_PRESCALE) begin
        PRDATA_OUT <= {31'h0000_0000, presc4};
      end else begin
        PRDATA_OUT <= 32'h0000_0000;
      end
    end
  end
  // =====================================================
  // pin synchronisers and crystal edge detect
  always @(posedge CORE_CLK_IN) begin
    crystal_input_sync <= {crystal_input_sync[1:0], CRYSTAL_INPUT_IN};
    rx_sync <= {rx_sync[0], RX_LINE_IN};
    modem_s1 <= MODEM_PINS_IN;
    modem_s2 <= modem_s1;
    rx_prev <= rx_sync[1];
    modem_prev <= modem_s2;
  end
  assign crystal_input_en = crystal_input_sync[1] && !crystal_input_sync[2];
  // strap passes two flops, taken on the first cycle after reset
  always @(posedge CORE_CLK_IN) begin
    strap_sync <= {strap_sync[0], PRESCALE_SELECT_PIN_IN};
    rst_d <= RST_IN;
    if (RST_IN) begin
      strap_presc4 <= 1'b0;
    end else if (rst_d) begin
      strap_presc4 <= strap_sync[1]; // RULE2
    end
  end
  assign presc4 = strap_presc4 || modem_control_register[`UBDS_MCR_PRESC]; // RULE2
  // =====================================================
  // one baud generator for transmitter and receiver; stops asleep
  ubds_baud_gen #(
    .DIV_W(DIV_W)
  ) u_baud (
    .clk_in(CORE_CLK_IN),
    .rst_in(RST_IN),
    .crystal_input_en_in(crystal_input_en),
    .run_in(!SLEEP_OUT), // RULE16
    .presc4_in(presc4),
    .divisor_in(divisor), // RULE5
    .tick16_out(BAUD_TICK16_OUT)
  );
  // RULE6 RULE7 follow from the divide chain above
  ubds_rx_idle u_idle (
    .clk_in(CORE_CLK_IN),
    .rst_in(RST_IN),
    .rx_in(rx_sync[1]),
    .tick16_in(BAUD_TICK16_OUT),
    .word_len_in(line_control[1:0]),
    .rx_has_data_in(!RX_FIFO_EMPTY_IN),
    .idle_out(rx_idle),
    .timeout_out(rx_timeout)
  );
  assign RX_TIMEOUT_OUT = rx_timeout;
  assign UART_CLK_EN_OUT = !SLEEP_OUT; // RULE16
  // =====================================================
  // sleep control
  assign wake = (rx_sync[1] != rx_prev) || (modem_s2 != modem_prev) || TX_WRITE_IN; // RULE17
  assign sleep_ok = enh && interrupt_enable_register[`UBDS_IER_SLEEP] // RULE13
    && rx_idle && TX_FIFO_EMPTY_IN && TX_SHIFT_EMPTY_IN && !OTHER_INT_PENDING_IN // RULE14
    && RX_FIFO_EMPTY_IN; // RULE15
  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      SLEEP_OUT <= 1'b0;
      wake_seen <= 1'b0;
    end else if (wake) begin
      SLEEP_OUT <= 1'b0; // RULE17
      wake_seen <= 1'b1;
    end else if (!sleep_ok) begin
      SLEEP_OUT <= 1'b0;
      wake_seen <= 1'b0;
    end else if (!wake_seen) begin
      SLEEP_OUT <= 1'b1;
    end
  end
  // =====================================================
  // transfer-ready outputs
  assign block_mode = fifo_control_register[`UBDS_FCR_FIFO_EN] && fifo_control_register[`UBDS_FCR_MODE]; // RULE8
  always @* begin
    next_transmit_ready_n_n = TRANSMIT_READY_N_OUT;
    next_receive_ready_n_n = RECEIVE_READY_N_OUT;
    if (!block_mode) begin
      next_transmit_ready_n_n = !TX_FIFO_EMPTY_IN; // RULE9
      next_receive_ready_n_n = RX_FIFO_EMPTY_IN; // RULE10
    end else begin
      if (TX_FIFO_FULL_IN) begin
        next_transmit_ready_n_n = 1'b1; // RULE11
      end else if (TX_TRIGGER_IN) begin
        next_transmit_ready_n_n = 1'b0;
      end
      if (RX_FIFO_EMPTY_IN || ERROR_IN_FIFO_FLAG_IN) begin
        next_receive_ready_n_n = 1'b1; // RULE12
      end else if (RX_TRIGGER_IN || rx_timeout) begin
        next_receive_ready_n_n = 1'b0;
      end
    end
  end
  always @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      TRANSMIT_READY_N_OUT <= 1'b0; // RULE22
      RECEIVE_READY_N_OUT <= 1'b1;
    end else begin
      TRANSMIT_READY_N_OUT <= next_transmit_ready_n_n;
      RECEIVE_READY_N_OUT <= next_receive_ready_n_n;
    end
  end
endmodule

// ===== verification/ubds_top_monitor.sv
// ubds_top_monitor.sv: port-level timing checks for ubds_top
// assumes: bound to ubds_top by the bench, one clock domain
`timescale 1ns/100ps
module ubds_top_monitor (
  input wire CORE_CLK_IN,
  input wire RST_IN,
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire PWRITE_IN,
  input wire [7:0] PADDR_IN,
  input wire [31:0] PWDATA_IN,
  input wire PSLVERR_OUT,
  input wire TX_FIFO_EMPTY_IN,
  input wire TX_SHIFT_EMPTY_IN,
  input wire TX_WRITE_IN,
  input wire RX_FIFO_EMPTY_IN,
  input wire ERROR_IN_FIFO_FLAG_IN,
  input wire OTHER_INT_PENDING_IN,
  input wire BAUD_TICK16_OUT,
  input wire SLEEP_OUT,
  input wire UART_CLK_EN_OUT,
  input wire TRANSMIT_READY_N_OUT,
  input wire RECEIVE_READY_N_OUT
);
  // ========
  // block mode as last written to fifo control
  logic blk;
  always @(posedge CORE_CLK_IN) begin
    if (RST_IN)
      blk <= 1'b0;
    else if (PSEL_IN && PENABLE_IN && PWRITE_IN && PADDR_IN == 8'h0C)
      blk <= PWDATA_IN[3] & PWDATA_IN[0];
  end
  // ========
  // properties
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);
  sequence s_asleep; SLEEP_OUT ##1 SLEEP_OUT; endsequence
  sequence s_blocked; !TX_FIFO_EMPTY_IN || !TX_SHIFT_EMPTY_IN || OTHER_INT_PENDING_IN; endsequence
  property p_reset; $fell(RST_IN) |-> !TRANSMIT_READY_N_OUT && RECEIVE_READY_N_OUT; endproperty
  a_reset: assert property (p_reset) else $error("ready levels wrong after reset");
  property p_slverr; PSEL_IN && PENABLE_IN && (PADDR_IN > 8'h20 || PADDR_IN[1:0] != 2'b00) |-> PSLVERR_OUT; endproperty
  a_slverr: assert property (p_slverr) else $error("bad address not refused");
  property p_tx_single; !blk && TX_FIFO_EMPTY_IN |=> !TRANSMIT_READY_N_OUT; endproperty
  a_tx_single: assert property (p_tx_single) else $error("tx ready missing when empty");
  property p_rx_single; !blk && !RX_FIFO_EMPTY_IN |=> !RECEIVE_READY_N_OUT; endproperty
  a_rx_single: assert property (p_rx_single) else $error("rx ready missing with data");
  property p_rx_err; blk && ERROR_IN_FIFO_FLAG_IN |=> RECEIVE_READY_N_OUT; endproperty
  a_rx_err: assert property (p_rx_err) else $error("rx ready active on error");
  property p_need; (s_blocked or !RX_FIFO_EMPTY_IN) and !SLEEP_OUT |=> !SLEEP_OUT; endproperty
  a_need: assert property (p_need) else $error("sleep entered while busy");
  property p_stop; s_asleep |-> !BAUD_TICK16_OUT && !UART_CLK_EN_OUT; endproperty
  a_stop: assert property (p_stop) else $error("clocks run while asleep");
  property p_wake; SLEEP_OUT && TX_WRITE_IN |-> ##[1:3] !SLEEP_OUT; endproperty
  a_wake: assert property (p_wake) else $error("no wake on transmit write");
endmodule

// ===== verification/ubds_far_model.sv
// ubds_far_model.sv: crystal source and serial receive line
// assumes: runs from the core clock, line idles high
`timescale 1ns/100ps
module ubds_far_model #(
  parameter HALF = 2
) (
  input wire clk_in,
  input wire line_low_in,
  output logic crystal_input_out,
  output wire rx_out
);
  // ========
  // crystal as a slow level, HALF core cycles per phase
  integer cnt = 0;
  initial crystal_input_out = 1'b0;
  always @(posedge clk_in) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1)
      crystal_input_out <= ~crystal_input_out;
  end
  // line pulled high, low only on request
  assign rx_out = !line_low_in;
endmodule

// ===== verification/tb_top.sv
// tb_top.sv: register, baud, ready and sleep scenarios for ubds_top
// assumes: rtl on the include path, far model gives crystal and rx line
`timescale 1ns/100ps
module tb_top;
  logic CORE_CLK_IN = 0, RST_IN = 1, PSEL_IN = 0, PENABLE_IN = 0, PWRITE_IN = 0;
  logic [7:0] PADDR_IN = 8'h00;
  logic [31:0] PWDATA_IN = 32'h0000_0000, PRDATA_OUT, rdata;
  logic [3:0] MODEM_PINS_IN = 4'h0;
  logic TX_FIFO_EMPTY_IN = 1, TX_FIFO_FULL_IN = 0, TX_SHIFT_EMPTY_IN = 1, TX_TRIGGER_IN = 0, TX_WRITE_IN = 0;
  logic RX_FIFO_EMPTY_IN = 1, RX_TRIGGER_IN = 0, ERROR_IN_FIFO_FLAG_IN = 0, OTHER_INT_PENDING_IN = 0;
  logic PREADY_OUT, PSLVERR_OUT, BAUD_TICK16_OUT, RX_TIMEOUT_OUT, SLEEP_OUT, UART_CLK_EN_OUT;
  logic TRANSMIT_READY_N_OUT, RECEIVE_READY_N_OUT, crystal_input, rx_line, err, line_low = 0, strap = 0;
  logic [2:0] mon;
  integer n_fail = 0, checks = 0, waited, i, k;
  // fifo ctrl, six status inputs, expected ready pair
  logic [15:0] dm [0:5] = '{16'h0091, 16'h0191, 16'h0002, 16'h0822, 16'h0928, 16'h0947};
  // modem ctrl and divisor
  logic [23:0] bt [0:3] = '{24'h00_000C, 24'h00_0014, 24'h00_0102, 24'h80_0003};
  assign mon = {BAUD_TICK16_OUT, RX_TIMEOUT_OUT, SLEEP_OUT};
  ubds_top u_ubds_top (.*, .CRYSTAL_INPUT_IN(crystal_input), .PRESCALE_SELECT_PIN_IN(strap), .RX_LINE_IN(rx_line));
  ubds_far_model u_ubds_far_model (.clk_in(CORE_CLK_IN), .line_low_in(line_low), .crystal_input_out(crystal_input), .rx_out(rx_line));
  initial forever #4 CORE_CLK_IN = ~CORE_CLK_IN;
  // ========
  // checking and closing
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks = checks + 1;
    if (s !== e) begin
      n_fail = n_fail + 1;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task end_of_test;
    $display("mismatches %0d comparisons %0d", n_fail, checks);
    if (n_fail == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task hang;
    n_fail = n_fail + 1;
    end_of_test;
  endtask
  // ========
  // apb transfer, request held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer n;
    @(posedge CORE_CLK_IN);
    {PSEL_IN, PWRITE_IN, PADDR_IN, PWDATA_IN} <= {1'b1, w, a, d};
    @(posedge CORE_CLK_IN);
    PENABLE_IN <= 1'b1;
    n = 0;
    do begin
      @(posedge CORE_CLK_IN);
      n = n + 1;
    end while (PREADY_OUT !== 1'b1 && n < 50);
    rdata = PRDATA_OUT;
    err = PSLVERR_OUT;
    {PSEL_IN, PENABLE_IN} <= 2'b00;
    if (n >= 50) hang;
  endtask
  // bounded wait on a watched output, cycles in waited
  task wfor(input integer s, input logic v, input integer lim);
    waited = 0;
    do begin
      @(negedge CORE_CLK_IN);
      waited = waited + 1;
    end while (mon[s] !== v && waited < lim);
    if (mon[s] !== v) hang;
  endtask
  // ticks seen over len cycles
  task cnt(input integer len);
    waited = 0;
    repeat (len) begin
      @(negedge CORE_CLK_IN);
      if (BAUD_TICK16_OUT !== 1'b0) waited = waited + 1;
    end
  endtask
  // ========
  // main sequence
  initial begin
    repeat (2) @(posedge CORE_CLK_IN);
    RST_IN <= 1'b0;
    @(negedge CORE_CLK_IN);
    chk("ready_n", 2'b01, {TRANSMIT_READY_N_OUT, RECEIVE_READY_N_OUT});
    // divisor bytes come up unknown; zero both so the counter clears
    apb(1'b1, 8'h00, 32'h0000_0000);
    apb(1'b1, 8'h04, 32'h0000_0000);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("line_ctrl", 32'h0000_001D, rdata);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("prescale", 32'h0000_0000, rdata);
    apb(1'b1, 8'h08, 32'h0000_002F);
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk("int_enable", 32'h0000_000F, rdata);
    apb(1'b0, 8'h24, 32'h0000_0000);
    chk("pslverr", 1'b1, err);
    chk("unmapped", 32'h0000_0000, rdata);
    apb(1'b0, 8'h02, 32'h0000_0000);
    chk("pslverr", 1'b1, err);
    apb(1'b1, 8'h18, 32'h0000_0010);
    apb(1'b1, 8'h08, 32'h0000_0020);
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk("int_enable", 32'h0000_0020, rdata);
    for (i = 0; i < 4; i = i + 1) begin
      apb(1'b1, 8'h14, {24'h00_0000, bt[i][23:16]});
      apb(1'b1, 8'h00, {24'h00_0000, bt[i][7:0]});
      apb(1'b1, 8'h04, {24'h00_0000, bt[i][15:8]});
      wfor(2, 1'b1, 6000);
      wfor(2, 1'b1, 6000);
      chk("tick_period", bt[i][15:0] * (bt[i][23] ? 4 : 1) * 4, waited);
    end
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("prescale", 32'h0000_0001, rdata);
    apb(1'b1, 8'h00, 32'h0000_0000);
    apb(1'b1, 8'h04, 32'h0000_0000);
    cnt(100);
    cnt(400);
    chk("ticks", 32'h0000_0000, waited);
    for (i = 0; i < 6; i = i + 1) begin
      apb(1'b1, 8'h0C, {24'h00_0000, dm[i][15:8]});
      @(posedge CORE_CLK_IN);
      {TX_FIFO_EMPTY_IN, TX_FIFO_FULL_IN, TX_TRIGGER_IN, RX_FIFO_EMPTY_IN, RX_TRIGGER_IN, ERROR_IN_FIFO_FLAG_IN} <= dm[i][7:2];
      repeat (3) @(negedge CORE_CLK_IN);
      chk("ready_n", dm[i][1:0], {TRANSMIT_READY_N_OUT, RECEIVE_READY_N_OUT});
    end
    apb(1'b1, 8'h0C, 32'h0000_0000);
    apb(1'b1, 8'h14, 32'h0000_0000);
    apb(1'b1, 8'h10, 32'h0000_0003);
    apb(1'b1, 8'h00, 32'h0000_0001);
    apb(1'b1, 8'h04, 32'h0000_0000);
    apb(1'b1, 8'h08, 32'h0000_0010);
    @(posedge CORE_CLK_IN);
    {TX_FIFO_EMPTY_IN, TX_FIFO_FULL_IN, TX_TRIGGER_IN, RX_FIFO_EMPTY_IN, RX_TRIGGER_IN, ERROR_IN_FIFO_FLAG_IN} <= 6'b100000;
    line_low <= 1'b1;
    repeat (8) @(posedge CORE_CLK_IN);
    line_low <= 1'b0;
    wfor(1, 1'b1, 6000);
    chk("timeout_wait", 1'b1, waited >= 2800 && waited <= 2900);
    chk("sleep", 1'b0, SLEEP_OUT);
    @(posedge CORE_CLK_IN);
    RX_FIFO_EMPTY_IN <= 1'b1;
    wfor(0, 1'b1, 20);
    cnt(100);
    chk("ticks", 32'h0000_0000, waited);
    chk("clk_en", 1'b0, UART_CLK_EN_OUT);
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk("status", 32'h0000_001A, rdata);
    for (k = 0; k < 3; k = k + 1) begin
      @(posedge CORE_CLK_IN);
      if (k == 0) TX_WRITE_IN <= 1'b1;
      else if (k == 1) MODEM_PINS_IN <= 4'hF;
      else line_low <= 1'b1;
      @(posedge CORE_CLK_IN);
      TX_WRITE_IN <= 1'b0;
      wfor(0, 1'b0, 10);
      @(posedge CORE_CLK_IN);
      OTHER_INT_PENDING_IN <= 1'b1;
      @(posedge CORE_CLK_IN);
      OTHER_INT_PENDING_IN <= 1'b0;
      if (k < 2) wfor(0, 1'b1, 20);
    end
    // second reset with the prescale strap high
    @(posedge CORE_CLK_IN);
    strap <= 1'b1;
    RST_IN <= 1'b1;
    repeat (2) @(posedge CORE_CLK_IN);
    RST_IN <= 1'b0;
    @(negedge CORE_CLK_IN);
    chk("ready_n", 2'b01, {TRANSMIT_READY_N_OUT, RECEIVE_READY_N_OUT});
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("prescale", 32'h0000_0001, rdata);
    end_of_test;
  end
endmodule
bind ubds_top ubds_top_monitor u_ubds_top_monitor (.*);
